// ===== hw/flcmd_map.vh
`ifndef FLCMD_MAP_VH
`define FLCMD_MAP_VH
`define FLCMD_MODE_CMD_ENTRY 4'h0
`define FLCMD_MODE_DATA  4'h1
`define FLCMD_OP_ERASE   16'h0008
`define FLCMD_OP_SETLK   16'h0009
`define FLCMD_OP_CLRLK   16'h000A
`define FLCMD_OP_GETLK   16'h000B
`define FLCMD_OP_PAGE_LOCK       16'h0002
`define FLCMD_OP_ERASE_PAGE_LOCK 16'h0004
`define FLCMD_OP_SETGP   16'h000C
`define FLCMD_OP_CLRGP   16'h000D
`define FLCMD_OP_GETGP   16'h000E
`define FLCMD_ERASE_ARG  16'h0000
`define FLCMD_ZERO16     16'h0000
`endif

// ===== hw/flcmd_bitop.v
`timescale 1ns/1ps
module flcmd_bitop #(
	parameter WIDTH = 16
) (
	// operands
	input  wire [WIDTH-1:0] curBits,
	input  wire [WIDTH-1:0] maskBits,
	input  wire             doSet,
	input  wire             doClr,
	// result
	output wire [WIDTH-1:0] newBits
);
	genvar i;
	generate
		for (i = 0; i < WIDTH; i = i + 1) begin : gBit
			assign newBits[i] = doSet ? (curBits[i] | maskBits[i]) :
				doClr ? (curBits[i] & ~maskBits[i]) : curBits[i];
		end
	endgenerate
endmodule

// ===== hw/flcmd_top.v
`timescale 1ns/1ps
`include "flcmd_map.vh"
module flcmd_top #(
	parameter LOCK_W = 16,
	parameter GP_W   = 16
) (
	// clock and reset
	input  wire        sys_clk,
	input  wire        rstn,
	// programmer handshake
	input  wire        wrStrobe,
	input  wire        rdStrobe,
	input  wire [3:0]  modeSel,
	input  wire [15:0] dataIn,
	output reg  [15:0] dataOut_ff,
	output reg         rdValid_ff,
	// page-lock request from page-write logic
	input  wire        pageLockReq,
	input  wire [15:0] pageLockMask,
	// array control
	output reg         eraseStart_ff,
	output reg         eraseAbort_ff,
	output reg  [15:0] lockBits_ff,
	output reg  [15:0] gpBits_ff
);
	localparam ST_IDLE = 2'h0;
	localparam ST_ARG  = 2'h1;
	localparam ST_READ = 2'h2;

	reg  [1:0]  state_ff;
	reg  [1:0]  nxt_state;
	reg  [15:0] opcode_ff;
	// opcode classes of the word on dataIn
	reg         known;
	reg         isRead;
	// argument actions for the pending opcode
	reg         setLkArg;
	reg         clrLkArg;
	reg         setGpArg;
	reg         clrGpArg;
	reg         eraseArg;
	wire        cmdWr;
	wire        dataWr;
	wire        dataRd;
	wire        argWr;
	wire        lkSet;
	wire        lkClr;
	wire [15:0] lkSetMask;
	wire [15:0] lockMid;
	wire        gpSet;
	wire        gpClr;
	wire [15:0] nxtLock;
	wire [15:0] nxtGp;

	assign cmdWr  = wrStrobe && (modeSel == `FLCMD_MODE_CMD_ENTRY);
	assign dataWr = wrStrobe && (modeSel == `FLCMD_MODE_DATA);
	assign dataRd = rdStrobe && (modeSel == `FLCMD_MODE_DATA);
	assign argWr  = (state_ff == ST_ARG) && dataWr;

	// opcode classes; anything not listed is not loaded and sends state_ff back to ST_IDLE
	always @* begin
		known  = 1'b0;
		isRead = 1'b0;
		case (dataIn)
			`FLCMD_OP_ERASE: begin
				known = 1'b1;
			end
			`FLCMD_OP_SETLK: begin
				known = 1'b1;
			end
			`FLCMD_OP_CLRLK: begin
				known = 1'b1;
			end
			`FLCMD_OP_SETGP: begin
				known = 1'b1;
			end
			`FLCMD_OP_CLRGP: begin
				known = 1'b1;
			end
			`FLCMD_OP_GETLK: begin
				isRead = 1'b1;
			end
			`FLCMD_OP_GETGP: begin
				isRead = 1'b1;
			end
			default: begin
				known  = 1'b0;
				isRead = 1'b0;
			end
		endcase
	end

	// what the data-mode write does for the pending opcode
	always @* begin
		setLkArg = 1'b0;
		clrLkArg = 1'b0;
		setGpArg = 1'b0;
		clrGpArg = 1'b0;
		eraseArg = 1'b0;
		if (argWr) begin
			case (opcode_ff)
				`FLCMD_OP_SETLK: begin
					setLkArg = 1'b1;
				end
				`FLCMD_OP_CLRLK: begin
					clrLkArg = 1'b1;
				end
				`FLCMD_OP_SETGP: begin
					setGpArg = 1'b1;
				end
				`FLCMD_OP_CLRGP: begin
					clrGpArg = 1'b1;
				end
				`FLCMD_OP_ERASE: begin
					eraseArg = (dataIn == `FLCMD_ERASE_ARG);
				end
				default: begin
					eraseArg = 1'b0;
				end
			endcase
		end
	end

	assign lkSet     = setLkArg || pageLockReq;
	assign lkClr     = clrLkArg;
	assign lkSetMask = (pageLockReq ? pageLockMask : `FLCMD_ZERO16) |
		(setLkArg ? dataIn : `FLCMD_ZERO16);
	assign gpSet     = setGpArg;
	assign gpClr     = clrGpArg;

	// clear first, then set, so a page lock in the same cycle wins
	flcmd_bitop #(.WIDTH(16)) uLockClr (
		.curBits  (lockBits_ff),
		.maskBits (dataIn),
		.doSet    (1'b0),
		.doClr    (lkClr),
		.newBits  (lockMid)
	);

	flcmd_bitop #(.WIDTH(16)) uLockSet (
		.curBits  (lockMid),
		.maskBits (lkSetMask),
		.doSet    (lkSet),
		.doClr    (1'b0),
		.newBits  (nxtLock)
	);

	flcmd_bitop #(.WIDTH(16)) uGp (
		.curBits  (gpBits_ff),
		.maskBits (dataIn),
		.doSet    (gpSet),
		.doClr    (gpClr),
		.newBits  (nxtGp)
	);

	// command sequencing; a new opcode write always restarts
	always @* begin
		nxt_state = state_ff;
		case (state_ff)
			ST_IDLE: begin
				if (cmdWr && known)
					nxt_state = ST_ARG;
				else if (cmdWr && isRead)
					nxt_state = ST_READ;
			end
			ST_ARG: begin
				if (cmdWr)
					nxt_state = known ? ST_ARG : (isRead ? ST_READ : ST_IDLE);
				else if (dataWr)
					nxt_state = ST_IDLE;
			end
			ST_READ: begin
				if (cmdWr)
					nxt_state = known ? ST_ARG : (isRead ? ST_READ : ST_IDLE);
				else if (dataRd)
					nxt_state = ST_IDLE;
			end
			default: nxt_state = ST_IDLE;
		endcase
	end

	always @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			state_ff      <= ST_IDLE;
			opcode_ff     <= `FLCMD_ZERO16;
			dataOut_ff    <= `FLCMD_ZERO16;
			rdValid_ff    <= 1'b0;
			eraseStart_ff <= 1'b0;
			eraseAbort_ff <= 1'b0;
			lockBits_ff   <= `FLCMD_ZERO16;
			gpBits_ff     <= `FLCMD_ZERO16;
		end else begin
			state_ff      <= nxt_state;
			rdValid_ff    <= 1'b0;
			eraseStart_ff <= 1'b0;
			eraseAbort_ff <= 1'b0;
			lockBits_ff   <= nxtLock;
			gpBits_ff     <= nxtGp;
			if (cmdWr && (known || isRead))
				opcode_ff <= dataIn;
			if (eraseArg) begin
				if (|lockBits_ff)
					eraseAbort_ff <= 1'b1;
				else
					eraseStart_ff <= 1'b1;
			end
			if (state_ff == ST_READ && dataRd && !cmdWr) begin
				rdValid_ff <= 1'b1;
				if (opcode_ff == `FLCMD_OP_GETLK)
					dataOut_ff <= lockBits_ff;
				else
					dataOut_ff <= gpBits_ff;
			end
		end
	end
endmodule

// ===== bench/flcmd_checker.sv
`timescale 1ns/1ps
`include "flcmd_map.vh"
module flcmd_checker (
	input        sys_clk, rstn, wrStrobe, rdStrobe, pageLockReq,
	input        rdValid_ff, eraseStart_ff, eraseAbort_ff,
	input [3:0]  modeSel,
	input [15:0] dataIn, pageLockMask, dataOut_ff, lockBits_ff, gpBits_ff
);
	reg  [15:0] op_ff;
	wire        dw = wrStrobe && modeSel == `FLCMD_MODE_DATA && !pageLockReq;
	wire        rw = rdStrobe && modeSel == `FLCMD_MODE_DATA;
	wire        ew = dw && op_ff == `FLCMD_OP_ERASE && dataIn == 16'h0000;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rstn);
	always @(posedge sys_clk or negedge rstn)
		if (!rstn) op_ff <= 16'hFFFF;
		else op_ff <= (wrStrobe && modeSel == `FLCMD_MODE_CMD_ENTRY) ? dataIn : 16'hFFFF;
	erase_go_a: assert property (ew && lockBits_ff == 16'h0000
		|=> eraseStart_ff && !eraseAbort_ff) else $error("erase not started");
	erase_refused_a: assert property (ew && lockBits_ff != 16'h0000
		|=> eraseAbort_ff && !eraseStart_ff) else $error("locked erase ran");
	lock_set_a: assert property (dw && op_ff == `FLCMD_OP_SETLK
		|=> lockBits_ff == ($past(lockBits_ff) | $past(dataIn))) else $error("set lock");
	lock_clear_a: assert property (dw && op_ff == `FLCMD_OP_CLRLK
		|=> lockBits_ff == ($past(lockBits_ff) & ~$past(dataIn))) else $error("clear lock");
	gp_set_a: assert property (dw && op_ff == `FLCMD_OP_SETGP
		|=> gpBits_ff == ($past(gpBits_ff) | $past(dataIn))) else $error("set gp");
	gp_clear_a: assert property (dw && op_ff == `FLCMD_OP_CLRGP
		|=> gpBits_ff == ($past(gpBits_ff) & ~$past(dataIn))) else $error("clear gp");
	lock_read_a: assert property (rw && op_ff == `FLCMD_OP_GETLK
		|=> rdValid_ff && dataOut_ff == $past(lockBits_ff)) else $error("lock read");
	gp_read_a: assert property (rw && op_ff == `FLCMD_OP_GETGP
		|=> rdValid_ff && dataOut_ff == $past(gpBits_ff)) else $error("gp read");
endmodule
bind flcmd_top flcmd_checker u_chk (.*);

// ===== bench/flcmd_prog.sv
`timescale 1ns/1ps
`include "flcmd_map.vh"
module flcmd_prog (
	input             sys_clk,
	output reg        wrStrobe = 1'b0,
	output reg        rdStrobe = 1'b0,
	output reg [3:0]  modeSel = 4'h0,
	output reg [15:0] dataIn = 16'h0000
);
	// opcode write, then one data write or data read
	task send(input [15:0] op, d, input rd);
		@(negedge sys_clk);
		{wrStrobe, modeSel, dataIn} = {1'b1, `FLCMD_MODE_CMD_ENTRY, op};
		@(negedge sys_clk);
		{wrStrobe, rdStrobe, modeSel, dataIn} = {!rd, rd, `FLCMD_MODE_DATA, d};
		@(negedge sys_clk);
		// released bus shows the inverse of the last word
		{wrStrobe, rdStrobe, dataIn} = {2'b00, ~d};
	endtask
endmodule

// ===== bench/flcmd_bench.sv
`timescale 1ns/1ps
`include "flcmd_map.vh"
module flcmd_bench;
	reg         sys_clk = 1'b0, rstn = 1'b0, pageLockReq = 1'b0;
	reg  [15:0] pageLockMask = 16'h0000, m, c;
	reg  [17:0] q[$], e;
	wire        wrStrobe, rdStrobe, rdValid_ff, eraseStart_ff, eraseAbort_ff;
	wire [3:0]  modeSel;
	wire [15:0] dataIn, dataOut_ff, lockBits_ff, gpBits_ff;
	integer     n_mismatch = 0, checked = 0, cyc = 0;
	flcmd_top u_dut (.*);
	flcmd_prog u_prog (.*);
	initial forever #2.5 sys_clk = ~sys_clk;
	task conclude;
		if (q.size() != 0) n_mismatch = n_mismatch + 1;
		$display("mismatches %0d checks %0d", n_mismatch, checked);
		if (n_mismatch == 0 && checked > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	// x holds {abort, start, read data} expected
	task cmd(input [15:0] op, d, input rd, input [17:0] x);
		if (rd || x[17:16] != 2'b00) q.push_back(x);
		u_prog.send(op, d, rd);
	endtask
	always @(negedge sys_clk) begin
		cyc = cyc + 1;
		if (cyc == 400) n_mismatch = n_mismatch + 1;
		if (cyc == 400) conclude;
		if (rdValid_ff | eraseStart_ff | eraseAbort_ff) begin
			e = q.pop_front();
			checked = checked + 1;
			if ({eraseAbort_ff, eraseStart_ff} !== e[17:16]
				|| (rdValid_ff === 1'b1 && dataOut_ff !== e[15:0])) begin
				n_mismatch = n_mismatch + 1;
				$display("MISMATCH %0t expected %h", $time, e);
			end
		end
	end
	initial begin
		m = 16'($urandom(39)) | 16'h0001;
		c = 16'($urandom);
		#15 rstn = 1'b1;
		cmd(`FLCMD_OP_SETLK, m, 1'b0, 18'h0);
		cmd(`FLCMD_OP_GETLK, 16'h0000, 1'b1, {2'b00, m});
		cmd(`FLCMD_OP_ERASE, 16'h0000, 1'b0, 18'h20000);
		cmd(`FLCMD_OP_CLRLK, c, 1'b0, 18'h0);
		cmd(`FLCMD_OP_GETLK, 16'h0000, 1'b1, {2'b00, m & ~c});
		cmd(`FLCMD_OP_CLRLK, 16'hFFFF, 1'b0, 18'h0);
		cmd(16'h00FF, 16'hFFFF, 1'b0, 18'h0);
		cmd(`FLCMD_OP_ERASE, 16'h0000, 1'b0, 18'h10000);
		cmd(`FLCMD_OP_SETGP, m, 1'b0, 18'h0);
		cmd(`FLCMD_OP_CLRGP, c, 1'b0, 18'h0);
		cmd(`FLCMD_OP_GETGP, 16'h0000, 1'b1, {2'b00, m & ~c});
		{pageLockMask, pageLockReq} = {c, 1'b1};
		@(negedge sys_clk) pageLockReq = 1'b0;
		cmd(`FLCMD_OP_GETLK, 16'h0000, 1'b1, {2'b00, c});
		repeat (3) @(negedge sys_clk);
		conclude;
	end
endmodule
